// ---- verilog/fbac_defines.vh ----
// Constants for the flash block access command interpreter
`ifndef FBAC_DEFINES_VH
`define FBAC_DEFINES_VH

// Storage geometry
`define FBAC_BLOCK_COUNT 16'h0077
`define FBAC_BLOCK_BYTES 16'h0200
`define FBAC_TOTAL_BYTES 16'hee00
`define FBAC_LAST_BLOCK 7'h76
`define FBAC_BLOCK_SHIFT 9
`define FBAC_BLOCK_W 7

// Frame addressing of the storage service
`define FBAC_CLUSTER_ID 16'h0023
`define FBAC_SERVICE_EP 8'he6

// Payload byte offsets
`define FBAC_OFS_CMD 4'h0
`define FBAC_OFS_OPT 4'h1
`define FBAC_OFS_BLK_HI 4'h2
`define FBAC_OFS_BLK_LO 4'h3
`define FBAC_OFS_OFF_HI 4'h4
`define FBAC_OFS_OFF_LO 4'h5
`define FBAC_OFS_CNT_HI 4'h6
`define FBAC_OFS_CNT_LO 4'h7
`define FBAC_OFS_DATA 4'h8

// Command and reply codes
`define FBAC_CMD_GEOMETRY 8'h00
`define FBAC_CMD_ERASE 8'h01
`define FBAC_RSP_GEOMETRY 8'h80
`define FBAC_RSP_ERASE 8'h81

// Status byte fields
`define FBAC_STAT_ERR_BIT 0
`define FBAC_STAT_OK 8'h00
`define FBAC_STAT_FAIL 8'h01

// Erased cell value
`define FBAC_ERASED_BYTE 8'hff

`endif

// ---- verilog/fbac_flash_store.v ----
// Storage array of the flash area with its block erase walker
`timescale 1ns/1ns
`include "fbac_defines.vh"
module fbac_flash_store (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Erase request from the interpreter
    input wire erase_start,
    input wire erase_all,
    input wire [`FBAC_BLOCK_W-1:0] erase_block,
    output reg erase_busy_ff,
    output reg erase_done_ff,
    // Application byte port
    input wire [15:0] app_addr,
    input wire app_wr,
    input wire [7:0] app_wdata,
    input wire app_rd,
    output reg [7:0] app_rdata_ff
);

    reg [7:0] mem [0:`FBAC_TOTAL_BYTES-1];
    reg [15:0] ptr_ff;
    reg [15:0] end_ff;
    wire [15:0] blk_base;
    wire app_in_range;

    assign blk_base = {erase_block, {`FBAC_BLOCK_SHIFT{1'b0}}};
    assign app_in_range = (app_addr < `FBAC_TOTAL_BYTES);

    // Erase walker: one byte per cycle, always whole blocks [RULE12] [RULE13]
    always @(posedge clk_sys) begin
        if (rst) begin
            erase_busy_ff <= 1'b0;
            erase_done_ff <= 1'b0;
            ptr_ff <= 16'h0000;
            end_ff <= 16'h0000;
        end else begin
            erase_done_ff <= 1'b0;
            if (erase_busy_ff) begin
                if (ptr_ff == end_ff) begin
                    erase_busy_ff <= 1'b0;
                    erase_done_ff <= 1'b1;
                end else begin
                    ptr_ff <= ptr_ff + 16'h0001;
                end
            end else if (erase_start) begin
                erase_busy_ff <= 1'b1;
                ptr_ff <= erase_all ? 16'h0000 : blk_base; // Index ignored for all [RULE13]
                end_ff <= erase_all ? (`FBAC_TOTAL_BYTES - 16'h0001)
                                    : (blk_base + `FBAC_BLOCK_BYTES - 16'h0001);
            end
        end
    end

    // Array writes; the erase owns the array, so application writes made while it runs are lost
    always @(posedge clk_sys) begin
        if (erase_busy_ff) begin
            mem[ptr_ff] <= `FBAC_ERASED_BYTE; // Every bit set to one [RULE12]
        end else if (app_wr && app_in_range) begin
            mem[app_addr] <= app_wdata; // Application modify path [RULE1]
        end
    end

    // Application read, data one cycle later; out of range reads as zero
    always @(posedge clk_sys) begin
        if (rst) begin
            app_rdata_ff <= 8'h00;
        end else if (app_rd) begin
            app_rdata_ff <= app_in_range ? mem[app_addr] : 8'h00; // [RULE1]
        end
    end

endmodule

// ---- verilog/fbac_top.v ----
// Command interpreter for block access to the user flash area
//
`timescale 1ns/1ns
`include "fbac_defines.vh"

// Function
// [RULE1] The device offers a non-volatile area of 119 equal blocks of 512 bytes to applications.
// [RULE2] Requesters send commands in frames addressed to cluster 0x23 on endpoint 0xE6.
// [RULE3] A request holds code at 0, option at 1, block at 2, offset at 4, count at 6, data at 8.
// [RULE4] Every multi-byte field travels with its most significant byte first.
// [RULE5] The byte count gives the number of data bytes, or for a read the bytes requested.
// [RULE6] A unicast command gets a unicast reply to the source endpoint, a broadcast none.
// [RULE7] The requester emits a reply as an explicit receive frame when so configured.
// [RULE8] The reply echoes the command layout with a status byte in place of the option.
// [RULE9] Status bit zero is one when the command failed, the other status bits are zero.
// [RULE10] A geometry query has all fields zero and no data bytes.
// [RULE11] The geometry reply carries block count, block size and a zero byte count.
// [RULE12] Erase sets every bit of the addressed block to one and only whole blocks.
// [RULE13] An erase with zero byte count erases every block and ignores the block index.
// [RULE14] An erase request has zero option and offset and no data bytes.
// [RULE15] The erase reply uses code 0x81, echoes block and offset and has zero byte count.
// [RULE16] A block index past the block count or an unknown code is reported as failure.
module fbac_top (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Request frame payload, one byte per handshake
    input wire rx_valid,
    input wire [7:0] rx_data,
    input wire rx_last,
    input wire [15:0] rx_cluster,
    input wire [7:0] rx_dst_ep,
    input wire [7:0] rx_src_ep,
    input wire rx_unicast,
    output reg rx_ready_ff,
    // Reply frame payload, one byte per handshake
    output reg tx_valid_ff,
    output reg [7:0] tx_data_ff,
    output reg tx_last_ff,
    output reg [7:0] tx_dst_ep_ff,
    output reg [7:0] tx_src_ep_ff,
    output reg [15:0] tx_cluster_ff,
    input wire tx_ready,
    // Application byte port to the flash area
    input wire [15:0] app_addr,
    input wire app_wr,
    input wire [7:0] app_wdata,
    input wire app_rd,
    output wire [7:0] app_rdata,
    // Status
    output reg busy_ff
);

    // Interpreter states
    localparam [2:0] ST_HDR = 3'd0;
    localparam [2:0] ST_SKIP = 3'd1;
    localparam [2:0] ST_EXEC = 3'd2;
    localparam [2:0] ST_ERASE = 3'd3;
    localparam [2:0] ST_SEND = 3'd4;

    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg [3:0] hdr_idx_ff;
    reg match_ff;
    reg unicast_ff;
    reg [7:0] src_ep_ff;
    reg [7:0] cmd_ff;
    reg [7:0] opt_ff;
    reg [15:0] blk_ff;
    reg [15:0] off_ff;
    reg [15:0] cnt_ff;
    reg [7:0] rsp_code_ff;
    reg [7:0] rsp_stat_ff;
    reg [15:0] rsp_blk_ff;
    reg [15:0] rsp_off_ff;
    reg [2:0] tx_idx_ff;
    reg erase_start_ff;
    reg erase_all_ff;
    reg [6:0] erase_blk_ff;
    reg [7:0] nxt_tx_byte;
    reg [2:0] nxt_tx_idx;

    wire rx_take;
    wire tx_take;
    wire hdr_done;
    wire frame_match;
    wire blk_in_range;
    wire [15:0] cnt_now;
    wire erase_busy;
    wire erase_done;

    assign rx_take = rx_valid && rx_ready_ff;
    assign tx_take = tx_valid_ff && tx_ready;
    assign hdr_done = (hdr_idx_ff == `FBAC_OFS_CNT_LO);
    // Only frames aimed at the storage service are acted on [RULE2]
    assign frame_match = (rx_cluster == `FBAC_CLUSTER_ID) && (rx_dst_ep == `FBAC_SERVICE_EP);
    assign blk_in_range = (blk_ff < `FBAC_BLOCK_COUNT);
    // The low count byte reaches cnt_ff on the same edge that ends an eight-byte frame,
    // so the decode takes it straight from the link then, or it would see a stale byte
    assign cnt_now = (state_ff == ST_HDR) ? {cnt_ff[15:8], rx_data} : cnt_ff; // [RULE13]

    // Next state
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_HDR: begin
                if (rx_take) begin
                    if (hdr_done) begin
                        nxt_state = rx_last ? (match_ff ? ST_EXEC : ST_HDR) : ST_SKIP;
                    end else if (rx_last) begin
                        nxt_state = ST_HDR; // Short payload is dropped without reply
                    end
                end
            end
            ST_SKIP: begin
                // Data bytes beyond the header are not used by these commands [RULE5]
                if (rx_take && rx_last) begin
                    nxt_state = match_ff ? ST_EXEC : ST_HDR;
                end
            end
            ST_EXEC: begin
                if (erase_start_ff) begin
                    nxt_state = ST_ERASE;
                end else begin
                    nxt_state = unicast_ff ? ST_SEND : ST_HDR; // [RULE6]
                end
            end
            ST_ERASE: begin
                if (erase_done) begin
                    nxt_state = unicast_ff ? ST_SEND : ST_HDR; // No broadcast reply [RULE6]
                end
            end
            ST_SEND: begin
                if (tx_take && tx_last_ff) begin
                    nxt_state = ST_HDR;
                end
            end
            default: begin
                nxt_state = ST_HDR;
            end
        endcase
    end

    // Header capture; two-byte fields arrive high byte first [RULE3] [RULE4]
    always @(posedge clk_sys) begin
        if (rst) begin
            hdr_idx_ff <= 4'h0;
            match_ff <= 1'b0;
            unicast_ff <= 1'b0;
            src_ep_ff <= 8'h00;
            cmd_ff <= 8'h00;
            opt_ff <= 8'h00;
            blk_ff <= 16'h0000;
            off_ff <= 16'h0000;
            cnt_ff <= 16'h0000;
        end else if (state_ff == ST_HDR && rx_take) begin
            hdr_idx_ff <= (hdr_done || rx_last) ? 4'h0 : hdr_idx_ff + 4'h1;
            case (hdr_idx_ff)
                `FBAC_OFS_CMD: begin
                    cmd_ff <= rx_data;
                    match_ff <= frame_match;
                    unicast_ff <= rx_unicast;
                    src_ep_ff <= rx_src_ep; // Reply goes back to this endpoint [RULE6]
                end
                `FBAC_OFS_OPT: opt_ff <= rx_data;
                `FBAC_OFS_BLK_HI: blk_ff[15:8] <= rx_data;
                `FBAC_OFS_BLK_LO: blk_ff[7:0] <= rx_data;
                `FBAC_OFS_OFF_HI: off_ff[15:8] <= rx_data;
                `FBAC_OFS_OFF_LO: off_ff[7:0] <= rx_data;
                `FBAC_OFS_CNT_HI: cnt_ff[15:8] <= rx_data;
                `FBAC_OFS_CNT_LO: cnt_ff[7:0] <= rx_data;
                default: cmd_ff <= cmd_ff;
            endcase
        end
    end

    // Decode of the completed header into the reply fields and the erase request.
    // Option and offset of a query or erase are not checked; the requester keeps them zero.
    always @(posedge clk_sys) begin
        if (rst) begin
            rsp_code_ff <= 8'h00;
            rsp_stat_ff <= `FBAC_STAT_OK;
            rsp_blk_ff <= 16'h0000;
            rsp_off_ff <= 16'h0000;
            erase_start_ff <= 1'b0;
            erase_all_ff <= 1'b0;
            erase_blk_ff <= 7'h00;
        end else if (nxt_state == ST_EXEC && state_ff != ST_EXEC) begin
            erase_start_ff <= 1'b0;
            erase_all_ff <= 1'b0;
            erase_blk_ff <= 7'h00;
            case (cmd_ff)
                `FBAC_CMD_GEOMETRY: begin
                    rsp_code_ff <= `FBAC_RSP_GEOMETRY; // [RULE10] [RULE11]
                    rsp_stat_ff <= `FBAC_STAT_OK;
                    rsp_blk_ff <= `FBAC_BLOCK_COUNT; // [RULE1] [RULE11]
                    rsp_off_ff <= `FBAC_BLOCK_BYTES; // [RULE11]
                end
                `FBAC_CMD_ERASE: begin
                    rsp_code_ff <= `FBAC_RSP_ERASE; // [RULE15]
                    rsp_blk_ff <= blk_ff; // Echo of block and offset [RULE15] [RULE14]
                    rsp_off_ff <= off_ff;
                    if (cnt_now == 16'h0000) begin
                        // Whole-area erase ignores the block index [RULE13]
                        rsp_stat_ff <= `FBAC_STAT_OK;
                        erase_start_ff <= 1'b1;
                        erase_all_ff <= 1'b1;
                    end else if (blk_in_range) begin
                        rsp_stat_ff <= `FBAC_STAT_OK;
                        erase_start_ff <= 1'b1;
                        erase_blk_ff <= blk_ff[6:0]; // [RULE12]
                    end else begin
                        rsp_stat_ff <= `FBAC_STAT_FAIL; // Block past the area [RULE16]
                    end
                end
                default: begin
                    // Unknown code is echoed as is and flagged [RULE8] [RULE16]
                    rsp_code_ff <= cmd_ff;
                    rsp_stat_ff <= `FBAC_STAT_FAIL; // [RULE9]
                    rsp_blk_ff <= blk_ff;
                    rsp_off_ff <= off_ff;
                end
            endcase
        end else begin
            erase_start_ff <= 1'b0;
        end
    end

    // Reply byte for the next slot; same layout as the request [RULE8] [RULE4]
    always @* begin
        nxt_tx_idx = tx_idx_ff + 3'd1;
        case (nxt_tx_idx)
            3'd0: nxt_tx_byte = rsp_code_ff;
            3'd1: nxt_tx_byte = rsp_stat_ff; // Only bit zero may be set [RULE9]
            3'd2: nxt_tx_byte = rsp_blk_ff[15:8];
            3'd3: nxt_tx_byte = rsp_blk_ff[7:0];
            3'd4: nxt_tx_byte = rsp_off_ff[15:8];
            3'd5: nxt_tx_byte = rsp_off_ff[7:0];
            default: nxt_tx_byte = 8'h00; // Byte count is always zero [RULE11] [RULE15]
        endcase
    end

    // Reply streaming; the code byte is loaded on entry, the rest per handshake
    always @(posedge clk_sys) begin
        if (rst) begin
            tx_valid_ff <= 1'b0;
            tx_data_ff <= 8'h00;
            tx_last_ff <= 1'b0;
            tx_idx_ff <= 3'd0;
            tx_dst_ep_ff <= 8'h00;
            tx_src_ep_ff <= 8'h00;
            tx_cluster_ff <= 16'h0000;
        end else if (nxt_state == ST_SEND && state_ff != ST_SEND) begin
            tx_valid_ff <= 1'b1;
            tx_data_ff <= rsp_code_ff;
            tx_last_ff <= 1'b0;
            tx_idx_ff <= 3'd0;
            tx_dst_ep_ff <= src_ep_ff; // Unicast back to the requesting endpoint [RULE6]
            tx_src_ep_ff <= `FBAC_SERVICE_EP; // Lets the requester route it as explicit [RULE7]
            tx_cluster_ff <= `FBAC_CLUSTER_ID;
        end else if (tx_take) begin
            if (tx_last_ff) begin
                tx_valid_ff <= 1'b0;
                tx_last_ff <= 1'b0;
                tx_idx_ff <= 3'd0;
            end else begin
                tx_data_ff <= nxt_tx_byte;
                tx_idx_ff <= nxt_tx_idx;
                tx_last_ff <= (nxt_tx_idx == 3'd7); // No data bytes follow the header
            end
        end
    end

    // State, receive ready and busy; ready is held low while a command is in work
    always @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= ST_HDR;
            rx_ready_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rx_ready_ff <= (nxt_state == ST_HDR) || (nxt_state == ST_SKIP);
            busy_ff <= (nxt_state == ST_EXEC) || (nxt_state == ST_ERASE) || erase_busy;
        end
    end

    // Flash area with its erase walker
    fbac_flash_store u_store (
        .clk_sys(clk_sys),
        .rst(rst),
        .erase_start(erase_start_ff),
        .erase_all(erase_all_ff),
        .erase_block(erase_blk_ff),
        .erase_busy_ff(erase_busy),
        .erase_done_ff(erase_done),
        .app_addr(app_addr),
        .app_wr(app_wr),
        .app_wdata(app_wdata),
        .app_rd(app_rd),
        .app_rdata_ff(app_rdata)
    );

endmodule

// ---- bench/fbac_properties.sv ----
// Concurrent checks on the ports of the flash block access interpreter
`timescale 1ns/1ns
module fbac_properties (
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Request link
    input wire rx_valid,
    input wire rx_last,
    input wire [15:0] rx_cluster,
    input wire [7:0] rx_dst_ep,
    input wire rx_unicast,
    input wire rx_ready_ff,
    // Reply link
    input wire tx_valid_ff,
    input wire [7:0] tx_data_ff,
    input wire tx_last_ff,
    input wire [7:0] tx_src_ep_ff,
    input wire [15:0] tx_cluster_ff,
    input wire tx_ready,
    input wire busy_ff
);
    reg [3:0] rx_cnt_ff;
    reg [3:0] tx_idx_ff;
    wire rx_take = rx_valid && rx_ready_ff;
    wire tx_take = tx_valid_ff && tx_ready;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Byte positions in the current frames; request count saturates past the header
    always @(posedge clk_sys) begin
        if (rst || (rx_take && rx_last)) begin
            rx_cnt_ff <= 4'h0;
        end else if (rx_take && rx_cnt_ff != 4'h8) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
        end
        if (rst || (tx_take && tx_last_ff)) begin
            tx_idx_ff <= 4'h0;
        end else if (tx_take) begin
            tx_idx_ff <= tx_idx_ff + 4'h1;
        end
    end
    property p_tx_hold;
        tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff) && $stable(tx_last_ff);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("reply byte changed before acceptance");
    property p_src_id;
        tx_valid_ff |-> tx_src_ep_ff == 8'he6 && tx_cluster_ff == 16'h0023;
    endproperty
    a_src_id: assert property (p_src_id)
        else $error("reply source endpoint or cluster wrong");
    property p_rx_block;
        tx_valid_ff |-> !rx_ready_ff;
    endproperty
    a_rx_block: assert property (p_rx_block)
        else $error("request taken while reply pending");
    property p_last_rel;
        tx_take && tx_last_ff |=> !tx_valid_ff && rx_ready_ff;
    endproperty
    a_last_rel: assert property (p_last_rel)
        else $error("link not released after last reply byte");
    property p_exec;
        rx_take && rx_last && rx_cnt_ff >= 4'h7 && rx_unicast && rx_cluster == 16'h0023
            && rx_dst_ep == 8'he6 |=> !rx_ready_ff && busy_ff;
    endproperty
    a_exec: assert property (p_exec)
        else $error("full request frame did not start execution");
    property p_status;
        tx_valid_ff && tx_idx_ff == 4'h1 |-> tx_data_ff[7:1] == 7'h00;
    endproperty
    a_status: assert property (p_status)
        else $error("reserved status bits set");
    property p_length;
        tx_valid_ff |-> tx_last_ff == (tx_idx_ff == 4'h7);
    endproperty
    a_length: assert property (p_length)
        else $error("reply not eight bytes long");
    property p_cnt_zero;
        tx_valid_ff && tx_idx_ff >= 4'h6 |-> tx_data_ff == 8'h00;
    endproperty
    a_cnt_zero: assert property (p_cnt_zero)
        else $error("reply byte count not zero");
endmodule

// ---- bench/fbac_requester.sv ----
// Requesting node model: sends request frames and sinks replies
`timescale 1ns/1ns
module fbac_requester (
    // Clock and stall control
    input wire clk_sys,
    input wire slow,
    // Request link
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic [15:0] rx_cluster,
    output logic [7:0] rx_dst_ep,
    output logic [7:0] rx_src_ep,
    output logic rx_unicast,
    input wire rx_ready_ff,
    // Reply link
    input wire tx_valid_ff,
    input wire [7:0] tx_data_ff,
    input wire [7:0] tx_dst_ep_ff,
    output logic tx_ready
);
    logic [7:0] rsp [$];
    logic [7:0] rsp_ep;
    // Idle link at time zero
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_last = 1'b0;
        rx_cluster = 16'h0000;
        rx_dst_ep = 8'h00;
        rx_src_ep = 8'h00;
        rx_unicast = 1'b0;
        tx_ready = 1'b0;
    end
    // Sink takes every byte, or every other cycle when stalling
    always @(posedge clk_sys) begin
        if (tx_valid_ff && tx_ready) begin
            rsp.push_back(tx_data_ff);
            rsp_ep <= tx_dst_ep_ff;
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // One frame: zero option, header big-endian, then n filler data bytes
    task automatic send(input logic [7:0] cmd, input logic [15:0] blk, input logic [15:0] off,
        input logic [15:0] cnt, input logic [7:0] n, input logic uc, input logic [15:0] cl);
        logic [63:0] hdr;
        integer i;
        hdr = {cmd, 8'h00, blk, off, cnt};
        @(posedge clk_sys);
        rx_cluster <= cl;
        rx_dst_ep <= 8'he6;
        rx_src_ep <= 8'h3c;
        rx_unicast <= uc;
        for (i = 0; i < 8 + n; i++) begin
            rx_valid <= 1'b1;
            rx_data <= (i < 8) ? hdr[63 - 8 * i -: 8] : 8'ha0 + i[7:0];
            rx_last <= (i == 7 + n);
            @(posedge clk_sys);
            while (rx_ready_ff !== 1'b1) @(posedge clk_sys);
        end
        // Released data line shows no stale byte
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~rx_data;
    endtask
endmodule

// ---- bench/tb.sv ----
// Testbench for the flash block access command interpreter
`timescale 1ns/1ns
module tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic rx_valid, rx_last, rx_unicast, rx_ready_ff, tx_valid_ff, tx_last_ff, tx_ready;
    logic app_wr, app_rd, busy_ff;
    logic [7:0] rx_data, rx_dst_ep, rx_src_ep, tx_data_ff, tx_dst_ep_ff, tx_src_ep_ff;
    logic [7:0] app_wdata, app_rdata;
    logic [15:0] rx_cluster, tx_cluster_ff, app_addr;
    logic [15:0] wa [0:4] = '{16'h53ff, 16'h5400, 16'h55ff, 16'h5600, 16'h0000};
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int i;
    fbac_top fbac_top_inst (.clk_sys, .rst, .rx_valid, .rx_data, .rx_last, .rx_cluster,
        .rx_dst_ep, .rx_src_ep, .rx_unicast, .rx_ready_ff, .tx_valid_ff, .tx_data_ff,
        .tx_last_ff, .tx_dst_ep_ff, .tx_src_ep_ff, .tx_cluster_ff, .tx_ready, .app_addr,
        .app_wr, .app_wdata, .app_rd, .app_rdata, .busy_ff);
    fbac_requester fbac_requester_inst (.clk_sys, .slow, .rx_valid, .rx_data, .rx_last,
        .rx_cluster, .rx_dst_ep, .rx_src_ep, .rx_unicast, .rx_ready_ff, .tx_valid_ff,
        .tx_data_ff, .tx_dst_ep_ff, .tx_ready);
    // 125 MHz clock
    always #4 clk_sys = ~clk_sys;
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Waits long enough for a whole-area erase, then compares all eight bytes
    task automatic expect_reply(input logic [63:0] exp);
        int n;
        int k;
        for (n = 0; n < 70000 && fbac_requester_inst.rsp.size() < 8; n++) @(posedge clk_sys);
        for (k = 0; k < 8; k++) chk("reply byte", {8'h00, exp[63 - 8 * k -: 8]},
            {8'h00, fbac_requester_inst.rsp[k]});
        chk("reply endpoint", 16'h003c, {8'h00, fbac_requester_inst.rsp_ep});
        fbac_requester_inst.rsp.delete();
    endtask
    task automatic expect_none;
        repeat (40) @(posedge clk_sys);
        chk("reply count", 16'h0000, 16'(fbac_requester_inst.rsp.size()));
    endtask
    task automatic app_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        app_addr <= a;
        app_wdata <= d;
        app_wr <= 1'b1;
        @(posedge clk_sys);
        app_wr <= 1'b0;
    endtask
    task automatic app_read_chk(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        app_addr <= a;
        app_rd <= 1'b1;
        @(posedge clk_sys);
        app_rd <= 1'b0;
        @(posedge clk_sys);
        chk("app byte", {8'h00, e}, {8'h00, app_rdata});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Hang guard well above the whole-area erase time
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // Main sequence
    initial begin
        app_addr = 16'h0000;
        app_wr = 1'b0;
        app_wdata = 8'h00;
        app_rd = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        fbac_requester_inst.send(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8000_0077_0200_0000);
        slow <= 1'b1;
        fbac_requester_inst.send(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8000_0077_0200_0000);
        slow <= 1'b0;
        fbac_requester_inst.send(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 1'b0, 16'h0023);
        expect_none();
        fbac_requester_inst.send(8'h00, 16'h0, 16'h0, 16'h0, 8'h0, 1'b1, 16'h0024);
        expect_none();
        fbac_requester_inst.send(8'h01, 16'h0100, 16'h0, 16'h0200, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8101_0100_0000_0000);
        fbac_requester_inst.send(8'h01, 16'h0077, 16'h0, 16'h0001, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8101_0077_0000_0000);
        fbac_requester_inst.send(8'h01, 16'h0076, 16'h0, 16'h0200, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8100_0076_0000_0000);
        fbac_requester_inst.send(8'h05, 16'h0003, 16'h1234, 16'h0002, 8'h2, 1'b1, 16'h0023);
        expect_reply(64'h0501_0003_1234_0000);
        for (i = 0; i < 5; i++) app_write(wa[i], 8'h5a);
        fbac_requester_inst.send(8'h01, 16'h002a, 16'h0, 16'h0200, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8100_002a_0000_0000);
        for (i = 0; i < 5; i++) app_read_chk(wa[i], (i == 1 || i == 2) ? 8'hff : 8'h5a);
        fbac_requester_inst.send(8'h01, 16'h0005, 16'h0, 16'h0000, 8'h0, 1'b1, 16'h0023);
        expect_reply(64'h8100_0005_0000_0000);
        for (i = 0; i < 5; i++) app_read_chk(wa[i], 8'hff);
        app_read_chk(16'hedff, 8'hff);
        app_read_chk(16'hee00, 8'h00);
        tally_and_finish();
    end
endmodule
bind fbac_top fbac_properties fbac_properties_inst (.clk_sys, .rst, .rx_valid, .rx_last,
    .rx_cluster, .rx_dst_ep, .rx_unicast, .rx_ready_ff, .tx_valid_ff, .tx_data_ff, .tx_last_ff,
    .tx_src_ep_ff, .tx_cluster_ff, .tx_ready, .busy_ff);
